// *** logic/gmci_cmd_table.sv ***
// Purpose: decode one command letter and argument into a settings update
// Assumes: argument already collected as a binary value
// Notes: pure combinational, no state
`timescale 1ns/10ps
module gmci_cmd_table (
  input wire logic [7:0] letter,
  input wire logic [7:0] arg,
  input wire gmci_pkg::gmci_cfg_t cfg_in,
  output gmci_pkg::gmci_cfg_t cfg_out,
  output logic bad
);
  always_comb begin
    cfg_out = cfg_in;
    bad = 1'b0;
    // ---------------------------------------------------------------
    // letter decode
    // ---------------------------------------------------------------
    if (letter == gmci_pkg::LTR_FORM) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.form_bin = arg[0];
    end else if (letter == gmci_pkg::LTR_SCALE) begin
      if (arg > 8'h03) bad = 1'b1;
      else cfg_out.scale = arg[1:0];
    end else if (letter == gmci_pkg::LTR_FILT) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.filt_on = arg[0];
    end else if (letter == gmci_pkg::LTR_HSK) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.hsk_wait = arg[0];
    end else if (letter == gmci_pkg::LTR_PAR) begin
      if (arg > 8'h03) bad = 1'b1;
      else cfg_out.parity = arg[1:0];
    end else if (letter == gmci_pkg::LTR_FUNC) begin
      if (arg > 8'h02) bad = 1'b1;
      else cfg_out.func = arg[1:0];
    end else if (letter == gmci_pkg::LTR_HDR) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.hdr_off = arg[0];
    end else if (letter == gmci_pkg::LTR_RANGE) begin
      if (arg > 8'h07) bad = 1'b1;
      else cfg_out.range = arg[2:0];
    end else if (letter == gmci_pkg::LTR_TRIG) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.trig_track = arg[0];
    end else if (letter == gmci_pkg::LTR_DELIM) begin
      if (arg > 8'h07) bad = 1'b1;
      else cfg_out.delim = arg[2:0];
    end else if (letter == gmci_pkg::LTR_DRIFT) begin
      if (arg > 8'h01) bad = 1'b1;
      else cfg_out.drift_each = arg[0];
    end else begin
      bad = 1'b1;
    end
    if (bad) cfg_out = cfg_in;
  end
endmodule

// *** logic/gmci_pkg.sv ***
// Purpose: shared constants and types for the meter bus command interpreter
// Assumes: ascii command bytes, one per valid strobe
// Notes: settings travel as one packed struct
package gmci_pkg;
  // ---------------------------------------------------------------
  // address and bus constants
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_DEFAULT = 5'h10;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CHR_0 = 8'h30;
  localparam logic [7:0] CHR_9 = 8'h39;
  localparam logic [7:0] ARG_MAX = 8'h0F;

  // ---------------------------------------------------------------
  // command letters
  // ---------------------------------------------------------------
  localparam logic [7:0] LTR_FORM = 8'h42;
  localparam logic [7:0] LTR_SCALE = 8'h44;
  localparam logic [7:0] LTR_FILT = 8'h46;
  localparam logic [7:0] LTR_HSK = 8'h48;
  localparam logic [7:0] LTR_PAR = 8'h4B;
  localparam logic [7:0] LTR_FUNC = 8'h4D;
  localparam logic [7:0] LTR_HDR = 8'h4E;
  localparam logic [7:0] LTR_RANGE = 8'h52;
  localparam logic [7:0] LTR_TRIG = 8'h54;
  localparam logic [7:0] LTR_DELIM = 8'h55;
  localparam logic [7:0] LTR_DRIFT = 8'h59;

  // ---------------------------------------------------------------
  // settings and their reset values
  // ---------------------------------------------------------------
  typedef struct packed {
    logic form_bin;
    logic [1:0] scale;
    logic filt_on;
    logic hsk_wait;
    logic [1:0] parity;
    logic [1:0] func;
    logic hdr_off;
    logic [2:0] range;
    logic trig_track;
    logic [2:0] delim;
    logic drift_each;
  } gmci_cfg_t;

  localparam gmci_cfg_t CFG_RESET = '{form_bin: 1'b0, scale: 2'h3, filt_on: 1'b0,
    hsk_wait: 1'b0, parity: 2'h0, func: 2'h0, hdr_off: 1'b0, range: 3'h0,
    trig_track: 1'b1, delim: 3'h0, drift_each: 1'b0};

  typedef enum logic [1:0] {
    GMCI_IDLE = 2'b00,
    GMCI_ARG = 2'b01,
    GMCI_SKIP = 2'b10
  } gmci_pst_t;

  // bus byte as seen by the interface: data and attention flag
  typedef struct packed {
    logic atn;
    logic [7:0] data;
  } gmci_byte_t;
endpackage

// *** logic/gmci_top.sv ***
// Purpose: device side bus address, local/remote state and command string parser
// Assumes: bus bytes arrive already handshaken as one-cycle strobes on clk
// Notes: switches and remote enable are pins and pass two flip-flops
//
// Operation
// - bus address read from five switches
// - listen and talk addresses from device address
// - talk-only switch: permanent talker, never listener
// - new address takes effect on selected device clear
// - released remote enable forces local
// - go-to-local returns a listening device to local
// - lockout with remote disables front panel
// - string is letter then integer, repeated
// - output form decimal or binary
// - scale length zero to three
// - filter off or on
// - handshake free-running or waits listener
// - parity none, odd, even, forced
// - function dc volts, resistance, ac volts
// - header literals normal or suppressed
// - range autorange or fixed one to seven
// - trigger single sample or track
// - record delimiter selection zero to seven
// - drift correction normal or each reading
`timescale 1ns/10ps
module gmci_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] addr_sw,
  input wire logic talk_only_sw,
  input wire logic ren_n,
  input wire logic byte_valid,
  input wire gmci_pkg::gmci_byte_t bus_byte,
  input wire logic panel_req,
  output logic listening,
  output logic talking,
  output logic remote,
  output logic lockout,
  output logic panel_en,
  output logic [4:0] active_addr,
  output gmci_pkg::gmci_cfg_t cfg,
  output logic cmd_error,
  output logic dev_clear
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  // no reset here: the chain must hold the real pins when reset lets go
  always_ff @(posedge clk) begin
    pin_meta <= {ren_n, talk_only_sw, addr_sw};
    pin_sync <= pin_meta;
  end
  logic [4:0] sw_addr;
  logic sw_talk_only;
  logic ren_rel;
  assign sw_addr = pin_sync[4:0];
  assign sw_talk_only = pin_sync[5];
  assign ren_rel = pin_sync[6];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic loaded;
    logic [4:0] addr;
    logic lsn;
    logic tlk;
    logic rem;
    logic llo;
    gmci_pkg::gmci_pst_t pst;
    logic [7:0] letter;
    logic [7:0] arg;
    logic err;
    logic clr;
    gmci_pkg::gmci_cfg_t cfg;
  } gmci_state_t;

  gmci_state_t st;
  gmci_state_t next_st;

  logic [7:0] my_listen;
  logic [7:0] my_talk;
  logic is_digit;
  logic [7:0] digit;
  logic [11:0] arg_mul;
  gmci_pkg::gmci_cfg_t tbl_cfg;
  logic tbl_bad;
  logic data_byte;
  logic cmd_byte;

  assign my_listen = gmci_pkg::LISTEN_BASE | {3'h0, st.addr};
  assign my_talk = gmci_pkg::TALK_BASE | {3'h0, st.addr};
  assign is_digit = bus_byte.data >= gmci_pkg::CHR_0 && bus_byte.data <= gmci_pkg::CHR_9;
  assign digit = bus_byte.data - gmci_pkg::CHR_0;
  assign arg_mul = {4'h0, st.arg} * 12'h00A + {4'h0, digit};
  assign data_byte = byte_valid && !bus_byte.atn && st.lsn;
  assign cmd_byte = byte_valid && bus_byte.atn;

  gmci_cmd_table gmci_cmd_table_inst (
    .letter(st.letter),
    .arg(st.arg),
    .cfg_in(st.cfg),
    .cfg_out(tbl_cfg),
    .bad(tbl_bad)
  );

  always_comb begin
    next_st = st;
    next_st.clr = 1'b0;
    next_st.err = 1'b0;
    // capture the address once after reset
    if (!st.loaded) begin
      next_st.addr = sw_addr;
      next_st.loaded = 1'b1;
    end
    // -------------------------------------------------------------
    // interface messages
    // -------------------------------------------------------------
    if (cmd_byte) begin
      if (bus_byte.data == my_listen && !sw_talk_only) begin
        next_st.lsn = 1'b1;
        if (!ren_rel) next_st.rem = 1'b1;
      end else if (bus_byte.data == gmci_pkg::CMD_UNL) begin
        next_st.lsn = 1'b0;
      end else if (bus_byte.data == my_talk) begin
        next_st.tlk = 1'b1;
        if (!ren_rel) next_st.rem = 1'b1;
      end else if (bus_byte.data == gmci_pkg::CMD_UNT ||
                   (bus_byte.data[7:5] == 3'h2 && bus_byte.data != my_talk)) begin
        next_st.tlk = 1'b0;
      end else if (bus_byte.data == gmci_pkg::CMD_GTL && st.lsn) begin
        next_st.rem = 1'b0;
      end else if (bus_byte.data == gmci_pkg::CMD_LLO) begin
        next_st.llo = 1'b1;
      end else if ((bus_byte.data == gmci_pkg::CMD_SDC && st.lsn) ||
                   bus_byte.data == gmci_pkg::CMD_DCL) begin
        // reload switches only here: a live switch change must not move us
        if (bus_byte.data == gmci_pkg::CMD_SDC) next_st.addr = sw_addr;
        next_st.cfg = gmci_pkg::CFG_RESET;
        next_st.pst = gmci_pkg::GMCI_IDLE;
        next_st.clr = 1'b1;
      end
    end
    // -------------------------------------------------------------
    // command string parser
    // -------------------------------------------------------------
    if (data_byte) begin
      case (st.pst)
        gmci_pkg::GMCI_IDLE: begin
          if (!is_digit) begin
            next_st.letter = bus_byte.data;
            next_st.arg = 8'h00;
            next_st.pst = gmci_pkg::GMCI_ARG;
          end else begin
            next_st.err = 1'b1;
          end
        end
        gmci_pkg::GMCI_ARG: begin
          if (is_digit) begin
            if (arg_mul > {4'h0, gmci_pkg::ARG_MAX}) begin
              next_st.arg = gmci_pkg::ARG_MAX;
            end else begin
              next_st.arg = arg_mul[7:0];
            end
            next_st.pst = gmci_pkg::GMCI_SKIP;
          end else begin
            next_st.err = 1'b1;
            next_st.letter = bus_byte.data;
            next_st.arg = 8'h00;
          end
        end
        gmci_pkg::GMCI_SKIP: begin
          if (is_digit) begin
            if (arg_mul > {4'h0, gmci_pkg::ARG_MAX}) begin
              next_st.arg = gmci_pkg::ARG_MAX;
            end else begin
              next_st.arg = arg_mul[7:0];
            end
          end else begin
            // a letter ends the previous command and opens the next
            next_st.cfg = tbl_cfg;
            next_st.err = tbl_bad;
            next_st.letter = bus_byte.data;
            next_st.arg = 8'h00;
            next_st.pst = gmci_pkg::GMCI_ARG;
          end
        end
        default: next_st.pst = gmci_pkg::GMCI_IDLE;
      endcase
    end else if (st.pst == gmci_pkg::GMCI_SKIP && (cmd_byte || !st.lsn) && !next_st.clr) begin
      // attention or unlisten closes the string, unless a clear wipes it
      next_st.cfg = tbl_cfg;
      next_st.err = tbl_bad;
      next_st.pst = gmci_pkg::GMCI_IDLE;
    end
    // talk-only overrides addressing
    if (sw_talk_only) begin
      next_st.tlk = 1'b1;
      next_st.lsn = 1'b0;
    end
    if (ren_rel) begin
      next_st.rem = 1'b0;
      next_st.llo = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '{loaded: 1'b0, addr: gmci_pkg::ADDR_DEFAULT, lsn: 1'b0, tlk: 1'b0,
        rem: 1'b0, llo: 1'b0, pst: gmci_pkg::GMCI_IDLE, letter: 8'h00, arg: 8'h00,
        err: 1'b0, clr: 1'b0, cfg: gmci_pkg::CFG_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign listening = st.lsn;
  assign talking = st.tlk;
  assign remote = st.rem;
  assign lockout = st.llo;
  // panel works in local unless lockout holds while remote is enabled
  assign panel_en = panel_req && !st.rem && !(st.llo && !ren_rel);
  assign active_addr = st.addr;
  assign cfg = st.cfg;
  assign cmd_error = st.err;
  assign dev_clear = st.clr;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_talk_only;
    @(posedge clk) disable iff (sys_rst) sw_talk_only |=> talking && !listening;
  endproperty
  a_talk_only: assert property (p_talk_only) else $error("talk-only not obeyed");

  property p_addr_hold;
    @(posedge clk) disable iff (sys_rst)
      st.loaded && !(cmd_byte && bus_byte.data == gmci_pkg::CMD_SDC) |=> $stable(active_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without clear");

  property p_sdc_load;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == gmci_pkg::CMD_SDC && listening
      |=> active_addr == $past(sw_addr) && dev_clear;
  endproperty
  a_sdc_load: assert property (p_sdc_load) else $error("clear did not load address");

  property p_ren_local;
    @(posedge clk) disable iff (sys_rst) ren_rel |=> !remote && !lockout;
  endproperty
  a_ren_local: assert property (p_ren_local) else $error("remote after release");

  property p_gtl;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == gmci_pkg::CMD_GTL && listening |=> !remote;
  endproperty
  a_gtl: assert property (p_gtl) else $error("go-to-local ignored");

  property p_lockout;
    @(posedge clk) disable iff (sys_rst) lockout && !ren_rel |-> !panel_en;
  endproperty
  a_lockout: assert property (p_lockout) else $error("panel live under lockout");

  property p_err_keep;
    @(posedge clk) disable iff (sys_rst) cmd_error |-> cfg == $past(cfg);
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("settings changed on error");

  sequence s_range_cmd;
    data_byte && bus_byte.data == gmci_pkg::LTR_RANGE && st.pst == gmci_pkg::GMCI_IDLE
    ##1 data_byte && bus_byte.data == 8'h32 && !cmd_byte
    ##1 cmd_byte && !data_byte;
  endsequence
  property p_range;
    @(posedge clk) disable iff (sys_rst) s_range_cmd |=> cfg.range == 3'h2;
  endproperty
  a_range: assert property (p_range) else $error("range command not applied");

  property p_bad_letter;
    @(posedge clk) disable iff (sys_rst)
      st.pst == gmci_pkg::GMCI_SKIP && data_byte && !is_digit && tbl_bad |=> cmd_error;
  endproperty
  a_bad_letter: assert property (p_bad_letter) else $error("bad command not flagged");

  property p_addr_load;
    @(posedge clk) disable iff (sys_rst)
      !st.loaded |=> active_addr == $past(sw_addr);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("switch address not taken");

  property p_listen_addr;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == my_listen && !sw_talk_only |=> listening;
  endproperty
  a_listen_addr: assert property (p_listen_addr) else $error("own listen address missed");

  property p_talk_addr;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == my_talk |=> talking;
  endproperty
  a_talk_addr: assert property (p_talk_addr) else $error("own talk address missed");

  property p_untalk;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data[7:5] == 3'h2 && bus_byte.data != my_talk && !sw_talk_only
      |=> !talking;
  endproperty
  a_untalk: assert property (p_untalk) else $error("other talker did not untalk");

  property p_remote_entry;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == my_listen && !sw_talk_only && !ren_rel |=> remote;
  endproperty
  a_remote_entry: assert property (p_remote_entry) else $error("remote not entered");

  property p_llo_set;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && bus_byte.data == gmci_pkg::CMD_LLO && !ren_rel |=> lockout;
  endproperty
  a_llo_set: assert property (p_llo_set) else $error("lockout not latched");

  property p_clear_cfg;
    @(posedge clk) disable iff (sys_rst)
      cmd_byte && (bus_byte.data == gmci_pkg::CMD_DCL ||
      (bus_byte.data == gmci_pkg::CMD_SDC && listening)) |=> cfg == gmci_pkg::CFG_RESET;
  endproperty
  a_clear_cfg: assert property (p_clear_cfg) else $error("clear left settings");

  property p_digit_first;
    @(posedge clk) disable iff (sys_rst)
      data_byte && st.pst == gmci_pkg::GMCI_IDLE && is_digit |=> cmd_error;
  endproperty
  a_digit_first: assert property (p_digit_first) else $error("bare digit not flagged");
endmodule

// *** test/gmci_ctrl_model.sv ***
// Purpose: bus controller model feeding handshaken bytes to the interpreter
// Assumes: every task is entered just after a rising clk edge
// Notes: each idle edge inverts the lines, so back-to-back idles alternate the inverse and a copy of the last byte
`timescale 1ns/10ps
module gmci_ctrl_model (
  input wire logic clk,
  output logic byte_valid,
  output gmci_pkg::gmci_byte_t bus_byte
);
  // ---------------------------------------------------------------
  // byte driver
  // ---------------------------------------------------------------
  initial begin
    byte_valid = 1'b0;
    bus_byte = '0;
  end

  // one byte per edge, back to back is legal
  task automatic put(input logic atn, input logic [7:0] d);
    byte_valid <= 1'b1;
    bus_byte <= '{atn: atn, data: d};
    @(posedge clk);
  endtask

  // released lines must not look like a stale byte
  task automatic quiet();
    byte_valid <= 1'b0;
    bus_byte <= ~bus_byte;
    @(posedge clk);
  endtask

  // selected clear is the only way a new switch address goes live after reset
  task automatic sel_clear(input logic [4:0] old);
    put(1'b1, gmci_pkg::LISTEN_BASE | {3'h0, old});
    put(1'b1, gmci_pkg::CMD_SDC);
    quiet();
  endtask

  // terminal parked in listen-only never addresses the meter
  task automatic listen_only(input int n);
    repeat (n) quiet();
  endtask
endmodule

// *** test/tb_gmci_top.sv ***
// Purpose: self-checking bench for the meter bus command interpreter
// Assumes: pins settle three edges after a change
// Notes: error and clear pulses are counted, not sampled by chance
`timescale 1ns/10ps
module tb_gmci_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] addr_sw = 5'h10;
  logic talk_only_sw = 1'b0;
  logic ren_n = 1'b1;
  logic panel_req = 1'b1;
  logic byte_valid;
  gmci_pkg::gmci_byte_t bus_byte;
  logic listening, talking, remote, lockout, panel_en, cmd_error, dev_clear;
  logic [4:0] active_addr;
  gmci_pkg::gmci_cfg_t cfg, old;
  int fail_count = 0;
  int total_checks = 0;
  int err_cnt = 0;
  int clr_cnt = 0;
  int e0;
  logic [4:0] cur_addr = 5'h10;
  string s = "xx";
  logic [7:0] ltr [11] = '{gmci_pkg::LTR_FORM, gmci_pkg::LTR_SCALE, gmci_pkg::LTR_FILT,
    gmci_pkg::LTR_HSK, gmci_pkg::LTR_PAR, gmci_pkg::LTR_FUNC, gmci_pkg::LTR_HDR,
    gmci_pkg::LTR_RANGE, gmci_pkg::LTR_TRIG, gmci_pkg::LTR_DELIM, gmci_pkg::LTR_DRIFT};
  int mx [11] = '{1, 3, 1, 1, 3, 2, 1, 7, 1, 7, 1};

  always #4 clk = ~clk;

  gmci_top gmci_top_inst (.clk(clk), .sys_rst(sys_rst), .addr_sw(addr_sw),
    .talk_only_sw(talk_only_sw), .ren_n(ren_n), .byte_valid(byte_valid),
    .bus_byte(bus_byte), .panel_req(panel_req), .listening(listening),
    .talking(talking), .remote(remote), .lockout(lockout), .panel_en(panel_en),
    .active_addr(active_addr), .cfg(cfg), .cmd_error(cmd_error), .dev_clear(dev_clear));
  gmci_ctrl_model gmci_ctrl_model_inst (.clk(clk), .byte_valid(byte_valid),
    .bus_byte(bus_byte));

  // ---------------------------------------------------------------
  // pulse counters and helpers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (cmd_error === 1'b1) err_cnt <= err_cnt + 1;
    if (dev_clear === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // addressed byte followed by idle, then let the state land
  task automatic atn(input logic [7:0] d);
    gmci_ctrl_model_inst.put(1'b1, d);
    gmci_ctrl_model_inst.quiet();
    wait_n(2);
  endtask

  // listen, data string, unlisten: the last command applies on unlisten
  task automatic cmd_str(input string t);
    gmci_ctrl_model_inst.put(1'b1, gmci_pkg::LISTEN_BASE | {3'h0, cur_addr});
    for (int i = 0; i < t.len(); i++) gmci_ctrl_model_inst.put(1'b0, t[i]);
    gmci_ctrl_model_inst.put(1'b1, gmci_pkg::CMD_UNL);
    gmci_ctrl_model_inst.quiet();
    wait_n(3);
  endtask

  function automatic logic [2:0] fld(input logic [7:0] l, input gmci_pkg::gmci_cfg_t c);
    case (l)
      gmci_pkg::LTR_FORM: fld = {2'h0, c.form_bin};
      gmci_pkg::LTR_SCALE: fld = {1'h0, c.scale};
      gmci_pkg::LTR_FILT: fld = {2'h0, c.filt_on};
      gmci_pkg::LTR_HSK: fld = {2'h0, c.hsk_wait};
      gmci_pkg::LTR_PAR: fld = {1'h0, c.parity};
      gmci_pkg::LTR_FUNC: fld = {1'h0, c.func};
      gmci_pkg::LTR_HDR: fld = {2'h0, c.hdr_off};
      gmci_pkg::LTR_RANGE: fld = c.range;
      gmci_pkg::LTR_TRIG: fld = {2'h0, c.trig_track};
      gmci_pkg::LTR_DELIM: fld = c.delim;
      default: fld = {2'h0, c.drift_each};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wait_n(12);
    sys_rst <= 1'b0;
    wait_n(4);
    check(active_addr, 5'h10, "default address");
    check({remote, listening, talking}, 3'h0, "idle after reset");
    atn(gmci_pkg::LISTEN_BASE | 8'h10);
    check({listening, remote}, 2'h2, "listen without remote enable");
    atn(gmci_pkg::TALK_BASE | 8'h10);
    check(talking, 1'b1, "own talk address");
    atn(gmci_pkg::TALK_BASE | 8'h03);
    check(talking, 1'b0, "other talk address");
    atn(gmci_pkg::CMD_UNL);
    ren_n <= 1'b0;
    wait_n(5);
    atn(gmci_pkg::LISTEN_BASE | 8'h10);
    check({remote, panel_en}, 2'h2, "remote when addressed");
    atn(gmci_pkg::CMD_GTL);
    check({remote, panel_en}, 2'h1, "go to local");
    atn(gmci_pkg::CMD_LLO);
    check({lockout, panel_en}, 2'h2, "panel locked out");
    ren_n <= 1'b1;
    wait_n(5);
    check({remote, panel_en}, 2'h1, "remote enable released");
    atn(gmci_pkg::CMD_UNL);
    // every argument of every command, then one past the top
    for (int i = 0; i < 11; i++) begin
      for (int v = 0; v <= mx[i] + 1; v++) begin
        s[0] = ltr[i];
        s[1] = 8'h30 + 8'(v);
        e0 = err_cnt;
        old = cfg;
        cmd_str(s);
        check(err_cnt - e0, (v > mx[i]) ? 1 : 0, "error pulses");
        if (v > mx[i]) check(cfg, old, "settings kept");
        else check(fld(ltr[i], cfg), v, "setting field");
      end
    end
    e0 = err_cnt;
    cmd_str("M2R5D1");
    check({cfg.func, cfg.range, cfg.scale}, {2'h2, 3'h5, 2'h1}, "chained string");
    check(err_cnt - e0, 0, "chained string clean");
    cmd_str("Z1R3");
    check(cfg.range, 3'h3, "command after bad one");
    cmd_str("R12");
    cmd_str("3");
    check(err_cnt - e0, 3, "bad letter, wide argument, bare digit");
    addr_sw <= 5'h11;
    wait_n(5);
    check(active_addr, 5'h10, "old address kept");
    e0 = clr_cnt;
    gmci_ctrl_model_inst.sel_clear(cur_addr);
    wait_n(3);
    check(active_addr, 5'h11, "new address live");
    check(clr_cnt - e0, 1, "clear pulse");
    check(cfg, gmci_pkg::CFG_RESET, "settings cleared");
    cur_addr = 5'h11;
    atn(gmci_pkg::CMD_UNL);
    atn(gmci_pkg::LISTEN_BASE | 8'h11);
    check(listening, 1'b1, "listen at new address");
    atn(gmci_pkg::CMD_UNL);
    talk_only_sw <= 1'b1;
    gmci_ctrl_model_inst.listen_only(5);
    check(talking, 1'b1, "permanent talker");
    atn(gmci_pkg::LISTEN_BASE | 8'h11);
    check(listening, 1'b0, "never listens");
    panel_req <= 1'b0;
    wait_n(1);
    check(panel_en, 1'b0, "no request, no panel action");
    give_verdict();
  end

  // the whole run is well under two thousand cycles
  initial begin
    wait_n(20000);
    fail_count++;
    give_verdict();
  end
endmodule
